// ===== rtl/t2cl_pkg.sv
// constants, field positions and state record of the timer two control block
// assumes the surrounding core decodes special-function space by address+page
package t2cl_pkg;

  // register addresses in special-function space, page 0
  localparam logic [7:0] T2CL_ADDR_CTRL = 8'hc8;
  localparam logic [7:0] T2CL_ADDR_RLDL = 8'hca;
  localparam logic [7:0] T2CL_ADDR_RLDH = 8'hcb;
  localparam logic [7:0] T2CL_ADDR_CNTL = 8'hcc;
  localparam logic [7:0] T2CL_ADDR_CNTH = 8'hcd;
  localparam logic [7:0] T2CL_PAGE      = 8'h00;

  // bit addresses of the control register share its upper five bits
  localparam int T2CL_BITSEL_LSB = 3;

  // control register fields
  localparam int T2CL_HOF  = 7;
  localparam int T2CL_LOF  = 6;
  localparam int T2CL_LIEN = 5;
  localparam int T2CL_CAPE = 4;
  localparam int T2CL_SPLT = 3;
  localparam int T2CL_RUN  = 2;
  localparam int T2CL_CSS  = 1;
  localparam int T2CL_XCLK = 0;

  localparam logic [7:0] T2CL_BYTE_RST  = 8'h00;
  localparam logic [7:0] T2CL_BYTE_MAX  = 8'hff;
  localparam logic [7:0] T2CL_BYTE_ONE  = 8'h01;

  // prescalers: core clock / 12 and external clock / 8
  localparam logic [3:0] T2CL_DIV12_LAST = 4'hb;
  localparam logic [3:0] T2CL_DIV12_ONE  = 4'h1;
  localparam logic [2:0] T2CL_DIV8_LAST  = 3'h7;
  localparam logic [2:0] T2CL_DIV8_ONE   = 3'h1;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [3:0] div12;
    logic       ext_prev;
    logic [2:0] ext_cnt;
    logic       osc_prev;
    logic       irq;
    logic       sel;
    logic [7:0] rdata;
  } t2cl_state_t;

  localparam t2cl_state_t T2CL_STATE_RST = '0;

endpackage : t2cl_pkg

// ===== rtl/t2cl_timer2_control.sv
// timer two: control register, counter and reload bytes, prescalers
// assumes a single-cycle special-function bus from the core, inputs
// already synchronous to clk, and usb_sof a one-cycle pulse; the
// interrupt enable and the per-byte fast clock selects live in other
// registers of the core and arrive here as plain levels
//
// Function
// - high flag sets when upper byte wraps; 16-bit mode on full wrap.
// - with timer interrupts enabled, a set high flag requests interrupt.
// - low flag sets on every lower byte wrap, in every mode.
// - hardware never clears the overflow flags; software must.
// - low enable plus timer enable: lower byte overflow requests interrupt.
// - capture enable: the event picked by capture source select copies counter into reload.
// - split mode: two 8-bit counters, each reloads its own byte; each wraps to zero instead when capture is enabled.
// - run bit gates counting; in split only the upper byte.
// - capture source select: 0 picks usb frame start, 1 oscillator fall.
// - external select: 0 core clock / 12, 1 external clock / 8.
// - each byte has its own fast clock select input.
// - control register at 0xc8 page 0, each bit individually writable.
// - 16-bit mode full wrap loads both reload bytes into counter; it loads zero when capture is enabled.
// - split mode: each byte reloads from its reload byte on wrap, or clears to zero with capture enabled.
// - interrupt requests only pass while timer_irq_enable_bit is set.
// - fast select 1 uses core clock; 0 uses external-select source.
`timescale 1ns/1ps
`default_nettype none

module t2cl_timer2_control
  import t2cl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // special-function bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_page,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic [7:0] sfr_bit_addr,
  input  wire logic       sfr_bit_val,
  // levels from other core registers
  input  wire logic       timer_irq_enable_bit,
  input  wire logic       high_byte_fast_clock_select,
  input  wire logic       low_byte_fast_clock_select,
  // clock and event inputs
  input  wire logic       ext_clk,
  input  wire logic       slow_oscillator,
  input  wire logic       usb_sof,
  // answers to the core
  output logic [7:0]      sfr_rdata,
  output logic            sfr_sel,
  output logic            timer_irq
);

  // byte access decode: address and page must both match
  function automatic logic t2cl_hit(
    input logic [7:0] addr,
    input logic [7:0] page,
    input logic [7:0] target
  );
    t2cl_hit = (addr == target) && (page == T2CL_PAGE);
  endfunction : t2cl_hit

  // bit addresses 0xc8..0xcf map onto control bits 0..7; page 0 only
  function automatic logic t2cl_bit_hit(
    input logic [7:0] bit_addr,
    input logic [7:0] page
  );
    t2cl_bit_hit = (bit_addr[7:T2CL_BITSEL_LSB]
                    == T2CL_ADDR_CTRL[7:T2CL_BITSEL_LSB])
                   && (page == T2CL_PAGE);
  endfunction : t2cl_bit_hit

  // a byte's count enable: the core clock when its fast select is set,
  // otherwise the prescaled tick picked by the external clock select
  function automatic logic t2cl_tick(
    input logic fast,
    input logic prescaled
  );
    t2cl_tick = fast || prescaled;
  endfunction : t2cl_tick

  // value a byte takes on wrap: zero in capture mode, where the reload
  // bytes hold captures, else its reload byte when reloading is due
  function automatic logic [7:0] t2cl_wrap_load(
    input logic       cap_mode,
    input logic       use_reload,
    input logic [7:0] reload
  );
    if (cap_mode || !use_reload) begin
      t2cl_wrap_load = T2CL_BYTE_RST;
    end else begin
      t2cl_wrap_load = reload;
    end
  endfunction : t2cl_wrap_load

  // next value of one counter byte: hold, step by one, or load on wrap
  function automatic logic [7:0] t2cl_step(
    input logic       inc,
    input logic       wrap,
    input logic [7:0] cur,
    input logic [7:0] load
  );
    t2cl_step = cur;
    if (inc) begin
      t2cl_step = wrap ? load : cur + T2CL_BYTE_ONE;
    end
  endfunction : t2cl_step

  // read mux over the mapped registers; unmapped addresses read zero
  function automatic logic [7:0] t2cl_read(
    input logic [7:0]  addr,
    input t2cl_state_t s
  );
    case (addr)
      T2CL_ADDR_CTRL: t2cl_read = s.ctrl;
      T2CL_ADDR_RLDL: t2cl_read = s.rld_lo;
      T2CL_ADDR_RLDH: t2cl_read = s.rld_hi;
      T2CL_ADDR_CNTL: t2cl_read = s.cnt_lo;
      T2CL_ADDR_CNTH: t2cl_read = s.cnt_hi;
      default:        t2cl_read = T2CL_BYTE_RST;
    endcase
  endfunction : t2cl_read

  // all state lives in one record, registered in one place
  t2cl_state_t st_reg;
  t2cl_state_t st_next;

  // address decode
  logic       hit_ctrl;
  logic       hit_rldl;
  logic       hit_rldh;
  logic       hit_cntl;
  logic       hit_cnth;
  logic       hit_map;
  logic       hit_bit;

  // control fields
  logic       split;
  logic       run;
  logic       capm;
  logic       ext_sel;
  logic       cap_sel;

  // clocking
  logic       div12_tick;
  logic       ext_edge;
  logic       ext8_tick;
  logic       slow_tick;
  logic       lo_tick;
  logic       hi_tick;

  // counting, capture and interrupt sources
  logic       lo_max;
  logic       hi_max;
  logic       lo_inc;
  logic       hi_inc;
  logic       lo_wrap;
  logic       hi_wrap;
  logic       osc_fall;
  logic       cap_src;
  logic       cap_evt;
  logic       hi_src;
  logic       lo_src;
  logic [7:0] lo_load;
  logic [7:0] hi_load;
  logic [7:0] rd_val;

  always_comb begin
    st_next = st_reg;

    // one decode per mapped register, shared by writes, reads and select
    hit_ctrl = t2cl_hit(sfr_addr, sfr_page, T2CL_ADDR_CTRL);
    hit_rldl = t2cl_hit(sfr_addr, sfr_page, T2CL_ADDR_RLDL);
    hit_rldh = t2cl_hit(sfr_addr, sfr_page, T2CL_ADDR_RLDH);
    hit_cntl = t2cl_hit(sfr_addr, sfr_page, T2CL_ADDR_CNTL);
    hit_cnth = t2cl_hit(sfr_addr, sfr_page, T2CL_ADDR_CNTH);
    hit_map  = hit_ctrl || hit_rldl || hit_rldh || hit_cntl || hit_cnth;
    // the bit path needs page 0 as well, like byte access
    hit_bit  = t2cl_bit_hit(sfr_bit_addr, sfr_page);

    // control fields as held before this cycle's writes
    split   = st_reg.ctrl[T2CL_SPLT];
    run     = st_reg.ctrl[T2CL_RUN];
    capm    = st_reg.ctrl[T2CL_CAPE];
    ext_sel = st_reg.ctrl[T2CL_XCLK];
    cap_sel = st_reg.ctrl[T2CL_CSS];

    // prescalers run free so the tick phase is independent of run control
    div12_tick = (st_reg.div12 == T2CL_DIV12_LAST);
    st_next.div12 = div12_tick ? 4'h0 : st_reg.div12 + T2CL_DIV12_ONE;
    // the external clock is taken as synchronous; its rises are counted
    ext_edge = ext_clk && !st_reg.ext_prev;
    st_next.ext_prev = ext_clk;
    ext8_tick = ext_edge && (st_reg.ext_cnt == T2CL_DIV8_LAST);
    if (ext_edge) begin
      st_next.ext_cnt = st_reg.ext_cnt + T2CL_DIV8_ONE;
    end
    slow_tick = ext_sel ? ext8_tick : div12_tick;
    lo_tick = t2cl_tick(low_byte_fast_clock_select,
                        slow_tick);
    hi_tick = t2cl_tick(high_byte_fast_clock_select,
                        slow_tick);

    // software writes; hardware updates below take precedence where stated
    if (sfr_wr && hit_ctrl) begin
      st_next.ctrl = sfr_wdata;
    end
    // a bit write changes only the addressed control bit
    if (sfr_bit_wr && hit_bit) begin
      st_next.ctrl[sfr_bit_addr[T2CL_BITSEL_LSB-1:0]]
        = sfr_bit_val;
    end
    // reload writes come first so a capture in the same cycle wins
    if (sfr_wr && hit_rldl) begin
      st_next.rld_lo = sfr_wdata;
    end
    if (sfr_wr && hit_rldh) begin
      st_next.rld_hi = sfr_wdata;
    end

    // counting
    lo_max = (st_reg.cnt_lo == T2CL_BYTE_MAX);
    hi_max = (st_reg.cnt_hi == T2CL_BYTE_MAX);
    // split mode leaves the low byte free running
    lo_inc = split ? lo_tick : (run && lo_tick);
    // in 16-bit mode the high byte steps on the low byte's wrap
    hi_inc = split ? (run && hi_tick)
                   : (lo_inc && lo_max);
    lo_wrap = lo_inc && lo_max;
    hi_wrap = hi_inc && hi_max;
    // the low byte reloads alone when split, else only on the full wrap
    lo_load = t2cl_wrap_load(capm, split || hi_max,
                             st_reg.rld_lo);
    hi_load = t2cl_wrap_load(capm, 1'b1,
                             st_reg.rld_hi);
    st_next.cnt_lo = t2cl_step(lo_inc, lo_wrap, st_reg.cnt_lo, lo_load);
    st_next.cnt_hi = t2cl_step(hi_inc, hi_wrap, st_reg.cnt_hi, hi_load);
    // counter byte writes win over a same-cycle increment
    if (sfr_wr && hit_cntl) begin
      st_next.cnt_lo = sfr_wdata;
    end
    if (sfr_wr && hit_cnth) begin
      st_next.cnt_hi = sfr_wdata;
    end

    // capture: an oscillator fall is a low level after a high one
    osc_fall = st_reg.osc_prev && !slow_oscillator;
    st_next.osc_prev = slow_oscillator;
    cap_src = cap_sel ? osc_fall : usb_sof;
    cap_evt = capm && cap_src;
    if (cap_evt) begin
      st_next.rld_lo = st_reg.cnt_lo;
      st_next.rld_hi = st_reg.cnt_hi;
    end

    // flags: only ever set here, so a same-cycle clear loses
    if (hi_wrap) begin
      st_next.ctrl[T2CL_HOF] = 1'b1;
    end
    if (lo_wrap) begin
      st_next.ctrl[T2CL_LOF] = 1'b1;
    end

    // request follows flags as a level; capture adds a one-cycle pulse;
    // sources use flags after this cycle's update, so a flag request drops
    // only when software clears the flag or an enable; the capture pulse ends by itself
    hi_src = st_next.ctrl[T2CL_HOF];
    lo_src = st_next.ctrl[T2CL_LIEN]
             && st_next.ctrl[T2CL_LOF];
    st_next.irq = timer_irq_enable_bit
                  && (hi_src || lo_src || cap_evt);

    // read answer one cycle later, sampled before this cycle's update
    rd_val = T2CL_BYTE_RST;
    if (sfr_rd && hit_map) begin
      rd_val = t2cl_read(sfr_addr, st_reg);
    end
    st_next.sel   = sfr_rd && hit_map;
    st_next.rdata = rd_val;
  end

  // synchronous reset clears every field, flags and counters included
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= T2CL_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output is a field of the registered record
  assign sfr_rdata = st_reg.rdata;
  assign sfr_sel   = st_reg.sel;
  assign timer_irq = st_reg.irq;

endmodule : t2cl_timer2_control

`default_nettype wire

// ===== testbench/t2cl_monitor.sv
// port checker for the timer two control block
// assumes it is bound onto t2cl_timer2_control
`timescale 1ns/1ps
`default_nettype none
module t2cl_monitor
  import t2cl_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic       sfr_bit_wr,
  input wire logic       timer_irq_enable_bit,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_sel,
  input wire logic       timer_irq
);
  logic rd_ctrl;
  logic quiet;
  // a write in the read cycle could clear a flag, so only quiet reads count
  assign rd_ctrl = sfr_rd && sfr_addr == T2CL_ADDR_CTRL
                   && sfr_page == T2CL_PAGE;
  assign quiet = rd_ctrl && timer_irq_enable_bit && !sfr_wr && !sfr_bit_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sel_needs_rd: assert property (sfr_sel |-> $past(sfr_rd))
    else $error("select without a read");
  a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without a read");
  a_ctrl_sel: assert property ($past(rd_ctrl) |-> sfr_sel)
    else $error("control read not selected");
  a_page_refused: assert property ($past(sfr_rd && sfr_page != 8'h00) |-> !sfr_sel)
    else $error("other page selected");
  a_gap_refused: assert property ($past(sfr_rd && sfr_addr == 8'hc9) |-> sfr_rdata == 8'h00)
    else $error("unmapped read gave data");
  a_irq_needs_ie: assert property (timer_irq |-> $past(timer_irq_enable_bit))
    else $error("interrupt while disabled");
  a_high_irq: assert property ($past(quiet) && sfr_rdata[7] |-> timer_irq)
    else $error("high flag without interrupt");
  a_low_irq: assert property ($past(quiet) && sfr_rdata[6] && sfr_rdata[5] |-> timer_irq)
    else $error("low flag without interrupt");
  c_irq: cover property ($rose(timer_irq));
  c_high: cover property (sfr_sel && sfr_rdata[7]);
  c_low: cover property ($past(rd_ctrl) && sfr_rdata[6]);
endmodule : t2cl_monitor
bind t2cl_timer2_control t2cl_monitor u_mon (.clk, .resetn, .sfr_addr,
  .sfr_page, .sfr_wr, .sfr_rd, .sfr_bit_wr, .timer_irq_enable_bit,
  .sfr_rdata, .sfr_sel, .timer_irq);
`default_nettype wire

// ===== testbench/t2cl_timer2_control_tb.sv
// scenario bench for the timer two control block
// assumes the checker file is compiled alongside for its bind
`timescale 1ns/1ps
`default_nettype none
module t2cl_timer2_control_tb
  import t2cl_pkg::*;
;
  logic       clk, resetn, wr, rd, bw, bv, ie, hf, lf, so, sof;
  logic       xc = 1'b0;
  logic [7:0] ad, pg, wd, ba, rdat;
  logic       sel, irq;
  int         err_count, total_checks;
  t2cl_timer2_control DUT (.clk(clk), .resetn(resetn), .sfr_addr(ad),
    .sfr_page(pg), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd),
    .sfr_bit_wr(bw), .sfr_bit_addr(ba), .sfr_bit_val(bv),
    .timer_irq_enable_bit(ie), .high_byte_fast_clock_select(hf),
    .low_byte_fast_clock_select(lf), .ext_clk(xc), .slow_oscillator(so),
    .usb_sof(sof), .sfr_rdata(rdat), .sfr_sel(sel), .timer_irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // free-running external clock, one rising edge every two cycles
  always @(posedge clk) xc <= ~xc;
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wb
  task automatic rb(input logic [7:0] a, e, m = 8'hff);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat & m, e & m);
  endtask : rb
  task automatic bit_wr(input logic [7:0] b, input logic v);
    @(posedge clk);
    ba <= b;
    bv <= v;
    bw <= 1'b1;
    @(posedge clk);
    bw <= 1'b0;
  endtask : bit_wr
  task automatic t_reset;
    rb(8'hc8, 8'h00);
    rb(8'hcb, 8'h00);
    @(posedge clk) pg <= 8'h01;
    wb(8'hca, 8'h5a);
    rb(8'hca, 8'h00);
    @(posedge clk) pg <= 8'h00;
    rb(8'hca, 8'h00);
    rb(8'hc9, 8'h00);
  endtask : t_reset
  task automatic t_wrap;
    wb(8'hca, 8'h34);
    wb(8'hcb, 8'h12);
    wb(8'hcc, 8'hfe);
    wb(8'hcd, 8'hff);
    @(posedge clk) lf <= 1'b1;
    bit_wr(8'hca, 1'b1);
    repeat (4) @(posedge clk);
    bit_wr(8'hca, 1'b0);
    rb(8'hc8, 8'hc0);
    rb(8'hcd, 8'h12);
    @(posedge clk) ie <= 1'b1;
    rb(8'hc8, 8'hc0);
    chk({7'h00, irq}, 8'h01);
    wb(8'hc8, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
  endtask : t_wrap
  task automatic t_split;
    @(posedge clk) ie <= 1'b0;
    wb(8'hc8, 8'h08);
    wb(8'hca, 8'h80);
    wb(8'hcc, 8'hfe);
    wb(8'hcd, 8'hfe);
    @(posedge clk) hf <= 1'b1;
    repeat (2) @(posedge clk);
    rb(8'hcd, 8'hfe);
    rb(8'hc8, 8'h48);
    rb(8'hcc, 8'h80, 8'hf0);
    @(posedge clk) ie <= 1'b1;
    bit_wr(8'hcd, 1'b1);
    rb(8'hc8, 8'h68);
    chk({7'h00, irq}, 8'h01);
  endtask : t_split
  task automatic t_capture;
    @(posedge clk) {ie, lf, hf} <= 3'h0;
    wb(8'hc8, 8'h12);
    wb(8'hcc, 8'h55);
    wb(8'hcd, 8'haa);
    @(posedge clk) sof <= 1'b1;
    @(posedge clk) sof <= 1'b0;
    rb(8'hca, 8'h80);
    @(posedge clk) so <= 1'b1;
    @(posedge clk) so <= 1'b0;
    rb(8'hca, 8'h55);
    rb(8'hcb, 8'haa);
    wb(8'hc8, 8'h10);
    wb(8'hcc, 8'h11);
    @(posedge clk) sof <= 1'b1;
    @(posedge clk) sof <= 1'b0;
    rb(8'hca, 8'h11);
  endtask : t_capture
  // run stays on for exactly 48 edges, a whole number of both prescales
  task automatic t_rate(input logic f, x, input logic [7:0] e);
    wb(8'hc8, {7'h00, x});
    wb(8'hcc, 8'h00);
    @(posedge clk) lf <= f;
    bit_wr(8'hca, 1'b1);
    repeat (46) @(posedge clk);
    bit_wr(8'hca, 1'b0);
    rb(8'hcc, e);
  endtask : t_rate
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  initial begin
    {resetn, wr, rd, bw, bv, ie, hf, lf, so, sof} = '0;
    {ad, pg, wd, ba} = '0;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_wrap;
    t_split;
    t_capture;
    t_rate(1'b1, 1'b1, 8'h30);
    t_rate(1'b0, 1'b0, 8'h04);
    t_rate(1'b0, 1'b1, 8'h03);
    close_out;
  end
  initial begin
    #20000;
    err_count++;
    close_out;
  end
endmodule : t2cl_timer2_control_tb
`default_nettype wire
